/* File: core/qmec_top.sv */
// Quad mode entry and exit control with an AXI4-Lite status port.
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps

module qmec_top #(
   parameter int AW = 4
) (
   input  wire logic          CLK,               // System clock.
   input  wire logic          SYS_RST,           // Synchronous reset, active high.
   input  wire logic [AW-1:0] S_AXI_AWADDR,      // Write address.
   input  wire logic          S_AXI_AWVALID,     // Write address valid.
   output logic               S_AXI_AWREADY,     // Write address ready.
   input  wire logic [31:0]   S_AXI_WDATA,       // Write data.
   input  wire logic [3:0]    S_AXI_WSTRB,       // Write byte strobes.
   input  wire logic          S_AXI_WVALID,      // Write data valid.
   output logic               S_AXI_WREADY,      // Write data ready.
   output logic [1:0]         S_AXI_BRESP,       // Write response.
   output logic               S_AXI_BVALID,      // Write response valid.
   input  wire logic          S_AXI_BREADY,      // Write response ready.
   input  wire logic [AW-1:0] S_AXI_ARADDR,      // Read address.
   input  wire logic          S_AXI_ARVALID,     // Read address valid.
   output logic               S_AXI_ARREADY,     // Read address ready.
   output logic [31:0]        S_AXI_RDATA,       // Read data.
   output logic [1:0]         S_AXI_RRESP,       // Read response.
   output logic               S_AXI_RVALID,      // Read data valid.
   input  wire logic          S_AXI_RREADY,      // Read data ready.
   input  wire logic          LINK_SCK,          // Serial clock from the host.
   input  wire logic          LINK_CS_N,         // Chip select, active low.
   input  wire logic [3:0]    QUAD_DATA_LINES_I, // Data lines in.
   output logic [3:0]         QUAD_DATA_LINES_O, // Data lines out.
   output logic [3:0]         QUAD_DATA_LINES_OE_N // Output enables, low drives.
);
   import qmec_pkg::*;

   if (AW < 3 || AW > 32) begin : g_chk
      $error("AW must be from 3 to 32");
   end

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Word decode of a bus address against a register offset.
   function automatic logic reg_hit(input logic [AW-1:0] a, input logic [31:0] ofs);
      return a[AW-1:2] == ofs[AW-1:2];
   endfunction

   // Byte that a read phase sends for the frame's command.
   function automatic logic [7:0] rd_byte(input logic qr, input logic [7:0] op,
                                         input logic [23:0] a, input logic [7:0] s1,
                                         input logic q, input logic [7:0] cf);
      logic [7:0] b;
      b = 8'h00;
      if (qr) begin
         b = a[7:0];
      end else if (op == OP_RDSR1) begin
         b = s1;
      end else if (op == OP_RDSR2) begin
         b[SR2_QE_BIT] = q;
      end else if (op == OP_RDAR && a == CFG_ADDR) begin
         b = cf;
      end
      return b;
   endfunction

   // ----------------------------------------------------------------
   // Link domain state
   // ----------------------------------------------------------------
   qmec_phase_t ph_r, ph_e;
   logic [5:0]  cnt_r, cnt_nxt;
   logic [5:0]  len;
   logic [31:0] sr_r, sr_nxt;
   logic [7:0]  op_r;
   logic [23:0] addr_r;
   logic [7:0]  tx_r;
   logic        qr_r, qr_e;
   logic        wb_r;
   logic [3:0]  fclk_r;
   logic        fok_r, fok_nxt;
   logic        wide, done, mrst;
   logic [7:0]  byte_in;
   logic        qe_r;
   logic [7:0]  sr1_r;
   logic [7:0]  cfg_r;
   logic        cont_r;
   logic        rst_en_r;
   logic        lr_s1, link_rst;
   logic        pw_tog_r;
   logic        pw_s1, pw_s2, pw_s3;
   logic        pw_ev;
   logic        fwide, rd_on;

   // Reset and power loss events carried into the serial clock domain.
   always_ff @(posedge LINK_SCK) begin
      lr_s1    <= SYS_RST;
      link_rst <= lr_s1;
      pw_s1    <= pw_tog_r;
      pw_s2    <= pw_s1;
      pw_s3    <= pw_s2;
   end
   assign pw_ev = pw_s2 ^ pw_s3;

   // Effective phase, bus width and completion of the current phase.
   always_comb begin
      ph_e    = (ph_r == PH_IDLE) ? (cont_r ? PH_ADDR : PH_CMD) : ph_r;
      qr_e    = qr_r | (ph_r == PH_IDLE && cont_r);
      wide    = cfg_r[CFG_QPI_BIT] | qr_e;
      sr_nxt  = wide ? {sr_r[27:0], QUAD_DATA_LINES_I} : {sr_r[30:0], QUAD_DATA_LINES_I[0]};
      cnt_nxt = cnt_r + (wide ? 6'h04 : 6'h01);
      unique case (ph_e)
         PH_ADDR:  len = LEN_ADDR;
         PH_DUMMY: len = LEN_DUMMY;
         default:  len = LEN_BYTE;
      endcase
      done    = (cnt_nxt == len) && (ph_e != PH_IGNORE);
      byte_in = sr_nxt[7:0];
      fok_nxt = fok_r & (QUAD_DATA_LINES_I == MODE_RST_NIB);
      mrst    = (fclk_r == MODE_RST_CLKS - 4'h1) && fok_nxt;
   end

   // Frame sequencing, cleared whenever the host deselects the device.
   always_ff @(posedge LINK_SCK or posedge LINK_CS_N) begin
      if (LINK_CS_N) begin
         ph_r   <= PH_IDLE;
         cnt_r  <= 6'h00;
         sr_r   <= 32'h0000_0000;
         op_r   <= 8'h00;
         addr_r <= 24'h000000;
         tx_r   <= 8'h00;
         qr_r   <= 1'b0;
         wb_r   <= 1'b0;
         fclk_r <= 4'h0;
         fok_r  <= 1'b1;
      end else begin
         sr_r  <= sr_nxt;
         fok_r <= fok_nxt;
         qr_r  <= qr_e;
         cnt_r <= done ? 6'h00 : cnt_nxt;
         if (fclk_r != MODE_RST_CLKS) begin
            fclk_r <= fclk_r + 4'h1;
         end
         if (ph_r == PH_IDLE) begin
            ph_r <= ph_e;
         end
         unique case (ph_e)
            PH_CMD: if (done) begin
               op_r <= byte_in;
               qr_r <= (byte_in == OP_QIOR);
               if (byte_in == OP_RDSR1 || byte_in == OP_RDSR2) begin
                  ph_r <= PH_RDATA;
                  tx_r <= rd_byte(1'b0, byte_in, addr_r, sr1_r, qe_r, cfg_r);
               end else if (byte_in == OP_WRSR) begin
                  ph_r <= PH_WDATA;
               end else if (byte_in == OP_RDAR || byte_in == OP_WRAR
                            || byte_in == OP_QIOR) begin
                  ph_r <= PH_ADDR;
               end else begin
                  ph_r <= PH_IGNORE;
               end
            end
            PH_ADDR: if (done) begin
               addr_r <= sr_nxt[23:0];
               if (qr_e) begin
                  ph_r <= PH_MODE;
               end else if (op_r == OP_RDAR) begin
                  ph_r <= PH_RDATA;
                  tx_r <= rd_byte(1'b0, op_r, sr_nxt[23:0], sr1_r, qe_r, cfg_r);
               end else begin
                  ph_r <= PH_WDATA;
               end
            end
            PH_MODE: if (done) begin
               ph_r <= PH_DUMMY;
            end
            PH_DUMMY: if (done) begin
               ph_r <= PH_RDATA;
               tx_r <= rd_byte(1'b1, op_r, addr_r, sr1_r, qe_r, cfg_r);
            end
            PH_WDATA: if (done) begin
               wb_r <= 1'b1;
               if (op_r != OP_WRSR || wb_r) begin
                  ph_r <= PH_IGNORE;
               end
            end
            PH_RDATA: if (done) begin
               addr_r <= addr_r + 24'h000001;
               tx_r   <= rd_byte(qr_e, op_r, addr_r + 24'h000001, sr1_r, qe_r, cfg_r);
            end else begin
               tx_r <= wide ? {tx_r[3:0], 4'h0} : {tx_r[6:0], 1'b0};
            end
            default: ;
         endcase
         if (mrst) begin
            ph_r <= PH_IGNORE;
         end
      end
   end

   // Persistent flags that live across frames.
   always_ff @(posedge LINK_SCK) begin
      if (link_rst) begin
         qe_r     <= QE_RST;
         sr1_r    <= SR1_RST;
         cfg_r    <= CFG_RST;
         cont_r   <= 1'b0;
         rst_en_r <= 1'b0;
      end else begin
         if (ph_e == PH_CMD && done) begin
            rst_en_r <= (byte_in == OP_RSTEN);
            if (byte_in == OP_RST && rst_en_r) begin
               cfg_r  <= CFG_RST;
               cont_r <= 1'b0;
            end
         end
         if (ph_e == PH_WDATA && done) begin
            if (op_r == OP_WRSR && !wb_r) begin
               sr1_r <= byte_in;
            end else if (op_r == OP_WRSR) begin
               qe_r <= byte_in[SR2_QE_BIT];
            end else if (addr_r == CFG_ADDR) begin
               cfg_r <= byte_in;
            end
         end
         if (ph_e == PH_MODE && done) begin
            if (cont_r) begin
               cont_r <= (byte_in[7:4] == MODE_KEEP_HI);
            end else begin
               cont_r <= (byte_in == MODE_ENTER) && qe_r;
            end
         end
         if (mrst) begin
            cont_r <= 1'b0;
         end
         if (pw_ev) begin
            cfg_r  <= CFG_RST;
            cont_r <= 1'b0;
         end
      end
   end

   // Read data leaves on the lines of the frame's width.
   assign fwide = cfg_r[CFG_QPI_BIT] | qr_r;
   assign rd_on = (ph_r == PH_RDATA);
   assign QUAD_DATA_LINES_O    = fwide ? tx_r[7:4] : {2'b00, tx_r[7], 1'b0};
   assign QUAD_DATA_LINES_OE_N = fwide ? {4{~rd_on}} : {2'b11, ~rd_on, 1'b1};

   // ----------------------------------------------------------------
   // System domain and bus slave
   // ----------------------------------------------------------------
   logic [3:0]    st_s1;
   logic [3:0]    st_s2;
   logic          aw_hold_r;
   logic [AW-1:0] aw_addr_r;
   logic          w_hold_r;
   logic [31:0]   w_data_r;
   logic [3:0]    w_strb_r;
   logic          bvalid_r;
   logic [1:0]    bresp_r;
   logic          rvalid_r;
   logic [31:0]   rdata_r;
   logic [1:0]    rresp_r;
   logic          wr_go;
   logic [31:0]   stat_word;

   // Link flags brought over as levels through two flip-flops.
   always_ff @(posedge CLK) begin
      st_s1 <= {rst_en_r, cont_r, cfg_r[CFG_QPI_BIT], qe_r};
      st_s2 <= st_s1;
   end

   // Status word seen by software.
   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[ST_QE]    = st_s2[0];
      stat_word[ST_QPI]   = st_s2[1];
      stat_word[ST_CONT]  = st_s2[2];
      stat_word[ST_RSTEN] = st_s2[3];
      stat_word[ST_QREQ_LSB+2:ST_QREQ_LSB] = QE_REQ_CODE;
   end

   assign S_AXI_AWREADY = ~aw_hold_r & ~bvalid_r;
   assign S_AXI_WREADY  = ~w_hold_r & ~bvalid_r;
   assign S_AXI_ARREADY = ~rvalid_r;
   assign S_AXI_BVALID  = bvalid_r;
   assign S_AXI_BRESP   = bresp_r;
   assign S_AXI_RVALID  = rvalid_r;
   assign S_AXI_RDATA   = rdata_r;
   assign S_AXI_RRESP   = rresp_r;
   assign wr_go         = aw_hold_r & w_hold_r & ~bvalid_r;

   // Write address and data are caught in either order.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         aw_hold_r <= 1'b0;
         aw_addr_r <= '0;
         w_hold_r  <= 1'b0;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= S_AXI_AWADDR;
         end else if (wr_go) begin
            aw_hold_r <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_hold_r <= 1'b1;
            w_data_r <= S_AXI_WDATA;
            w_strb_r <= S_AXI_WSTRB;
         end else if (wr_go) begin
            w_hold_r <= 1'b0;
         end
      end
   end

   // Write response; a power loss request toggles toward the link.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
         pw_tog_r <= 1'b0;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r  <= RESP_OKAY;
         if (reg_hit(aw_addr_r, OFS_CTRL)) begin
            if (w_strb_r[0] && w_data_r[CTRL_PWR_BIT]) begin
               pw_tog_r <= ~pw_tog_r;
            end
         end else if (!reg_hit(aw_addr_r, OFS_STAT)) begin
            bresp_r <= RESP_SLVERR;
         end
      end else if (S_AXI_BREADY) begin
         bvalid_r <= 1'b0;
      end
   end

   // Read channel answers one cycle after the address is taken.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OKAY;
      end else if (S_AXI_ARVALID && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rresp_r  <= RESP_OKAY;
         rdata_r  <= 32'h0000_0000;
         if (reg_hit(S_AXI_ARADDR, OFS_STAT)) begin
            rdata_r <= stat_word;
         end else if (!reg_hit(S_AXI_ARADDR, OFS_CTRL)) begin
            rresp_r <= RESP_SLVERR;
         end
      end else if (S_AXI_RREADY) begin
         rvalid_r <= 1'b0;
      end
   end
endmodule

/* File: core/qmec_pkg.sv */
// Constants and types of the quad mode entry and exit control block.
package qmec_pkg;
   // Serial command opcodes.
   localparam logic [7:0]  OP_RDSR1      = 8'h05;
   localparam logic [7:0]  OP_RDSR2      = 8'h35;
   localparam logic [7:0]  OP_WRSR       = 8'h01;
   localparam logic [7:0]  OP_RDAR       = 8'h65;
   localparam logic [7:0]  OP_WRAR       = 8'h71;
   localparam logic [7:0]  OP_RSTEN      = 8'h66;
   localparam logic [7:0]  OP_RST        = 8'h99;
   localparam logic [7:0]  OP_QIOR       = 8'hEB;
   // Configuration location and bit positions.
   localparam logic [23:0] CFG_ADDR      = 24'h800003;
   localparam int          CFG_QPI_BIT   = 6;
   localparam int          SR2_QE_BIT    = 1;
   localparam logic [2:0]  QE_REQ_CODE   = 3'h5;
   // Mode byte values of the continuous read.
   localparam logic [7:0]  MODE_ENTER    = 8'hA5;
   localparam logic [3:0]  MODE_KEEP_HI  = 4'hA;
   localparam logic [3:0]  MODE_RST_NIB  = 4'hF;
   localparam logic [3:0]  MODE_RST_CLKS = 4'h8;
   // Phase lengths in bits.
   localparam logic [5:0]  LEN_BYTE      = 6'h08;
   localparam logic [5:0]  LEN_ADDR      = 6'h18;
   localparam logic [5:0]  LEN_DUMMY     = 6'h10;
   // Reset values.
   localparam logic [7:0]  SR1_RST       = 8'h00;
   localparam logic [7:0]  CFG_RST       = 8'h00;
   localparam logic        QE_RST        = 1'b0;
   // Register map and fields.
   localparam logic [31:0] OFS_CTRL      = 32'h0000_0000;
   localparam logic [31:0] OFS_STAT      = 32'h0000_0004;
   localparam int          CTRL_PWR_BIT  = 0;
   localparam int          ST_QE         = 0;
   localparam int          ST_QPI        = 1;
   localparam int          ST_CONT       = 2;
   localparam int          ST_RSTEN      = 3;
   localparam int          ST_QREQ_LSB   = 4;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   // Phases of one serial frame.
   typedef enum logic [2:0] {
      PH_IDLE, PH_CMD, PH_ADDR, PH_MODE, PH_DUMMY, PH_WDATA, PH_RDATA, PH_IGNORE
   } qmec_phase_t;
endpackage

/* File: sim/qmec_checker.sv */
// Concurrent checks on the bus and link ports of the quad mode control.
`timescale 1ns/1ps
module qmec_checker #(
   parameter int AW = 4
) (
   input wire logic          CLK,                 // Clock.
   input wire logic          SYS_RST,             // Reset.
   input wire logic          S_AXI_AWVALID,       // AW valid.
   input wire logic          S_AXI_AWREADY,       // AW ready.
   input wire logic          S_AXI_WVALID,        // W valid.
   input wire logic          S_AXI_WREADY,        // W ready.
   input wire logic [1:0]    S_AXI_BRESP,         // B response.
   input wire logic          S_AXI_BVALID,        // B valid.
   input wire logic          S_AXI_BREADY,        // B ready.
   input wire logic [AW-1:0] S_AXI_ARADDR,        // AR address.
   input wire logic          S_AXI_ARVALID,       // AR valid.
   input wire logic          S_AXI_ARREADY,       // AR ready.
   input wire logic [31:0]   S_AXI_RDATA,         // R data.
   input wire logic [1:0]    S_AXI_RRESP,         // R response.
   input wire logic          S_AXI_RVALID,        // R valid.
   input wire logic          S_AXI_RREADY,        // R ready.
   input wire logic          LINK_SCK,            // Serial clock.
   input wire logic          LINK_CS_N,           // Chip select.
   input wire logic [3:0]    QUAD_DATA_LINES_OE_N // Line enables.
);
   import qmec_pkg::*;
   // Request shapes that start a bus answer.
   sequence s_wboth;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence s_rstat;
      S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == OFS_STAT[AW-1:0];
   endsequence
   sequence s_rbad;
      S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR != OFS_STAT[AW-1:0]
         && S_AXI_ARADDR != OFS_CTRL[AW-1:0];
   endsequence
   // Bus timing and holding, then status content and link drive shape.
   chk_write_answer: assert property (@(posedge CLK) disable iff (SYS_RST)
      s_wboth |-> ##2 S_AXI_BVALID) else $error("write not answered");
   chk_bresp_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write answer dropped");
   chk_read_answer: assert property (@(posedge CLK) disable iff (SYS_RST)
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read not answered");
   chk_rdata_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read answer dropped");
   chk_busy_refuse: assert property (@(posedge CLK) disable iff (SYS_RST)
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("took write while busy");
   chk_qe_code: assert property (@(posedge CLK) disable iff (SYS_RST)
      s_rstat |=> S_AXI_RDATA[6:4] == QE_REQ_CODE && S_AXI_RDATA[31:7] == 25'h0)
      else $error("status code field wrong");
   chk_cont_needs_qe: assert property (@(posedge CLK) disable iff (SYS_RST)
      s_rstat |=> S_AXI_RDATA[ST_QE] || !S_AXI_RDATA[ST_CONT])
      else $error("continuous read armed without quad enable");
   chk_unmapped_rd: assert property (@(posedge CLK) disable iff (SYS_RST)
      s_rbad |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0)
      else $error("unmapped read not refused");
   chk_idle_release: assert property (@(posedge CLK) disable iff (SYS_RST)
      LINK_CS_N [*2] |-> QUAD_DATA_LINES_OE_N == 4'hF) else $error("lines driven while idle");
   chk_drive_shape: assert property (@(posedge LINK_SCK) disable iff (LINK_CS_N)
      QUAD_DATA_LINES_OE_N inside {4'hF, 4'hD, 4'h0}) else $error("odd line enables");
endmodule

/* File: sim/qmec_host_model.sv */
// Behavioural serial host that frames commands on the quad data lines.
`timescale 1ns/1ps
module qmec_host_model (
   output logic            sck,  // Serial clock, still between frames.
   output logic            cs_n, // Chip select, active low.
   output logic [3:0]      hd,   // Host side of the data lines.
   input  wire logic [3:0] din   // Resolved data lines.
);
   localparam int HALF = 32;
   // Idle levels from time zero.
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      hd = 4'h0;
   end
   // Runs clock edges with the device deselected.
   task automatic idle(input int n);
      repeat (n) begin
         #HALF sck = 1'b1;
         #HALF sck = 1'b0;
      end
   endtask
   task automatic sel();
      cs_n = 1'b0;
      #HALF;
   endtask
   // Every frame is closed by deselecting before the next starts.
   task automatic desel();
      #HALF cs_n = 1'b1;
      #(2 * HALF);
   endtask
   // Sends one byte, MSB first, on line 0 or on all four lines.
   task automatic sb(input logic [7:0] b, input bit q);
      for (int i = 0; i < (q ? 2 : 8); i++) begin
         if (q) hd = b[7 - 4 * i -: 4];
         else hd = {~hd[3:1], b[7 - i]};
         #HALF sck = 1'b1;
         #HALF sck = 1'b0;
      end
   endtask
   task automatic sa(input logic [23:0] a, input bit q);
      sb(a[23:16], q);
      sb(a[15:8], q);
      sb(a[7:0], q);
   endtask
   // Receives one byte; released lines toggle so stale levels cannot pass.
   task automatic rb(input bit q, output logic [7:0] b);
      for (int i = 0; i < (q ? 2 : 8); i++) begin
         hd = ~hd;
         #HALF sck = 1'b1;
         if (q) b = {b[3:0], din};
         else b = {b[6:0], din[1]};
         #HALF sck = 1'b0;
      end
   endtask
endmodule

/* File: sim/test_quad_mode_entry_exit_control.sv */
// Self-checking bench of the quad mode entry and exit control.
`timescale 1ns/1ps
bind qmec_top qmec_checker #(.AW(AW)) qmec_checker_inst (.CLK, .SYS_RST, .S_AXI_AWVALID,
   .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
   .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
   .S_AXI_RREADY, .LINK_SCK, .LINK_CS_N, .QUAD_DATA_LINES_OE_N);
module test_quad_mode_entry_exit_control;
   import qmec_pkg::*;
   localparam logic [7:0] QPI_M = 8'h01 << CFG_QPI_BIT;
   logic        clk = 1'b0, sys_rst = 1'b1;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, v, seed = 32'h35;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire         awready, wready, bvalid, arready, rvalid, sck, cs_n;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire [3:0]   dout, oe_n, hd, lines_i;
   logic [7:0]  b, s1, s2, d;
   logic [23:0] a;
   logic [1:0]  r;
   int          err_total = 0, compares = 0, cycles = 0;
   // The wire shows the device where it drives and the host elsewhere.
   assign lines_i = (hd & oe_n) | (dout & ~oe_n);
   always #2.5 clk = ~clk;
   qmec_top #(.AW(4)) qmec_top_inst (.CLK(clk), .SYS_RST(sys_rst), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .LINK_SCK(sck),
      .LINK_CS_N(cs_n), .QUAD_DATA_LINES_I(lines_i), .QUAD_DATA_LINES_O(dout),
      .QUAD_DATA_LINES_OE_N(oe_n));
   qmec_host_model qmec_host_model_inst (.sck(sck), .cs_n(cs_n), .hd(hd), .din(lines_i));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic results();
      if (err_total == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   // Bus write: both channels offered together, response taken a cycle late.
   task automatic axw(input logic [3:0] ad, input logic [31:0] dt, output logic [1:0] rs);
      @(posedge clk);
      awaddr <= ad;
      wdata <= dt;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b1;
      @(posedge clk);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic axr(input logic [3:0] ad, output logic [31:0] dt, output logic [1:0] rs);
      @(posedge clk);
      araddr <= ad;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b1;
      @(posedge clk);
      dt = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic stat(output logic [31:0] st);
      logic [1:0] rs;
      repeat (8) @(posedge clk);
      axr(OFS_STAT[3:0], st, rs);
   endtask
   // Serial frames built from host byte transfers.
   task automatic frame1(input logic [7:0] op, input bit q);
      qmec_host_model_inst.sel();
      qmec_host_model_inst.sb(op, q);
      qmec_host_model_inst.desel();
   endtask
   task automatic fill(input logic [7:0] x);
      qmec_host_model_inst.sel();
      repeat (4) qmec_host_model_inst.sb(x, 1'b1);
      qmec_host_model_inst.desel();
   endtask
   task automatic rdreg(input logic [7:0] op, input bit q, output logic [7:0] x);
      qmec_host_model_inst.sel();
      qmec_host_model_inst.sb(op, q);
      if (op == OP_RDAR) qmec_host_model_inst.sa(CFG_ADDR, q);
      qmec_host_model_inst.rb(q, x);
      qmec_host_model_inst.desel();
   endtask
   task automatic wrcfg(input logic [7:0] x, input bit q);
      qmec_host_model_inst.sel();
      qmec_host_model_inst.sb(OP_WRAR, q);
      qmec_host_model_inst.sa(CFG_ADDR, q);
      qmec_host_model_inst.sb(x, q);
      qmec_host_model_inst.desel();
   endtask
   task automatic qrd(input bit cont, input logic [7:0] md, input logic [23:0] ad,
                      output logic [7:0] x);
      qmec_host_model_inst.sel();
      if (!cont) qmec_host_model_inst.sb(OP_QIOR, 1'b0);
      qmec_host_model_inst.sa(ad, 1'b1);
      qmec_host_model_inst.sb(md, 1'b1);
      qmec_host_model_inst.sb(ad[15:8], 1'b1);
      qmec_host_model_inst.sb(ad[23:16], 1'b1);
      qmec_host_model_inst.rb(1'b1, x);
      qmec_host_model_inst.desel();
   endtask
   // Cuts a hang short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         err_total++;
         results();
      end
   end
   // Main sequence.
   initial begin
      fork
         qmec_host_model_inst.idle(3);
         repeat (10) @(posedge clk);
      join
      @(posedge clk);
      sys_rst <= 1'b0;
      stat(v);
      chk(v, {25'h0, QE_REQ_CODE, 4'h0});
      axr(4'h8, v, r);
      chk({v[29:0], r}, {30'h0, RESP_SLVERR});
      axw(4'hC, rnd(), r);
      chk(r, RESP_SLVERR);
      for (int k = 0; k < 2; k++) begin
         v = rnd();
         s1 = v[7:0];
         s2 = {v[15:10], k[0], v[8]};
         a = v[31:8];
         qmec_host_model_inst.sel();
         qmec_host_model_inst.sb(OP_WRSR, 1'b0);
         qmec_host_model_inst.sb(s1, 1'b0);
         qmec_host_model_inst.sb(s2, 1'b0);
         qmec_host_model_inst.desel();
         rdreg(OP_RDSR1, 1'b0, b);
         chk(b, s1);
         rdreg(OP_RDSR2, 1'b0, b);
         chk(b[SR2_QE_BIT], k[0]);
         stat(v);
         chk(v[ST_QE], k[0]);
         qrd(1'b0, MODE_ENTER, a, d);
         chk(d, a[7:0]);
         stat(v);
         chk(v[ST_CONT], k[0]);
      end
      qrd(1'b1, {MODE_KEEP_HI, s1[3:0]}, a, d);
      stat(v);
      chk({d, v[ST_CONT]}, {a[7:0], 1'b1});
      qrd(1'b1, 8'h00, a, d);
      stat(v);
      chk({d, v[ST_CONT]}, {a[7:0], 1'b0});
      qrd(1'b0, MODE_ENTER, a, d);
      // All ones for 8 edges must drop the frame: released lines then read back 0Fh.
      qrd(1'b1, {MODE_RST_NIB, MODE_RST_NIB}, {6{MODE_RST_NIB}}, d);
      stat(v);
      chk({d, v[ST_CONT]}, {8'h0F, 1'b0});
      rdreg(OP_RDAR, 1'b0, b);
      chk(b, CFG_RST);
      wrcfg(b | QPI_M, 1'b0);
      stat(v);
      chk(v[ST_QPI], 1'b1);
      rdreg(OP_RDAR, 1'b1, b);
      chk(b, QPI_M);
      wrcfg(b & ~QPI_M, 1'b1);
      rdreg(OP_RDAR, 1'b0, b);
      chk(b, 8'h00);
      wrcfg(QPI_M, 1'b0);
      axw(OFS_CTRL[3:0], 32'h1, r);
      fill(8'h00);
      stat(v);
      chk({r, v[ST_QPI], v[ST_QE]}, {RESP_OKAY, 2'b01});
      wrcfg(QPI_M, 1'b0);
      frame1(OP_RST, 1'b1);
      stat(v);
      chk(v[ST_QPI], 1'b1);
      frame1(OP_RSTEN, 1'b1);
      stat(v);
      chk(v[ST_RSTEN], 1'b1);
      frame1(OP_RST, 1'b1);
      stat(v);
      chk(v[ST_QPI], 1'b0);
      rdreg(OP_RDAR, 1'b0, b);
      chk(b, 8'h00);
      results();
   end
endmodule
